// ===== rtl/frms_params.svh
// Constants of the FIFO reset and mode select block
`ifndef FRMS_PARAMS_SVH
`define FRMS_PARAMS_SVH
// Storage geometry
`define FRMS_DW 18
`define FRMS_AW 9
`define FRMS_DEPTH 10'h200
`define FRMS_HALF 10'h100
// Reset defaults and the read-suppress control bit position
`define FRMS_OFS_DEF 9'h03F
`define FRMS_CTRL_ENH_DEF 6'h3F
`define FRMS_CTRL_CMP_DEF 6'h00
`define FRMS_CTRL_RDSUP 5
// Register byte addresses
`define FRMS_A_CTRL 8'h00
`define FRMS_A_AE_OFS 8'h04
`define FRMS_A_AF_OFS 8'h08
`define FRMS_A_STATUS 8'h0C
`define FRMS_A_IRQ_STAT 8'h10
`define FRMS_A_IRQ_MASK 8'h14
// Interrupt bit positions
`define FRMS_IRQ_OVF 0
`define FRMS_IRQ_UDF 1
`define FRMS_IRQ_FULL 2
`define FRMS_IRQ_EMPTY 3
// Bus answers
`define FRMS_RESP_OKAY 2'h0
`define FRMS_RESP_SLVERR 2'h2
`endif

// ===== rtl/frms_pkg.sv
// Types shared by the FIFO reset and mode select block
`include "frms_params.svh"
package frms_pkg;
   typedef logic [`FRMS_DW-1:0] frms_word_t; // One stored word
   typedef logic [`FRMS_AW-1:0] frms_ptr_t;  // Storage index
   typedef logic [`FRMS_AW:0] frms_cnt_t;    // Fill level 0..512
   typedef logic [5:0] frms_ctrl_t;          // Control bits 00-05
   typedef logic [3:0] frms_irq_t;           // Interrupt events
   typedef logic [7:0] frms_addr_t;          // Register byte address
endpackage : frms_pkg

// ===== rtl/frms_if.sv
// Carriers between the top, the bus slave and the storage array
`timescale 1ns/10ps
`default_nettype none
interface frms_reg_if;
   import frms_pkg::*;
   logic wr_en;          // One-cycle register write
   frms_addr_t wr_addr;  // Write address
   logic [31:0] wr_data; // Write data
   logic [31:0] wr_mask; // Byte lanes as bit mask
   logic wr_hit;         // Write address is mapped
   frms_addr_t rd_addr;  // Read address
   logic [31:0] rd_data; // Read data
   logic rd_hit;         // Read address is mapped
   modport bus(output wr_en, wr_addr, wr_data, wr_mask, rd_addr,
      input wr_hit, rd_data, rd_hit);
   modport regs(input wr_en, wr_addr, wr_data, wr_mask, rd_addr,
      output wr_hit, rd_data, rd_hit);
endinterface : frms_reg_if

interface frms_mem_if;
   import frms_pkg::*;
   logic wr_en;          // Store a word
   frms_ptr_t wr_ptr;    // Store index
   frms_word_t wr_data;  // Word stored
   logic rd_en;          // Fetch a word
   frms_ptr_t rd_ptr;    // Fetch index
   frms_word_t rd_data;  // Output register
   modport ctl(output wr_en, wr_ptr, wr_data, rd_en, rd_ptr, input rd_data);
   modport mem(input wr_en, wr_ptr, wr_data, rd_en, rd_ptr, output rd_data);
endinterface : frms_mem_if
`default_nettype wire

// ===== rtl/frms_mem.sv
// Storage array of the FIFO with a registered read port
`timescale 1ns/10ps
`default_nettype none
module frms_mem (
   input wire logic clk,
   input wire logic arst_n,
   frms_mem_if.mem mif
);
   import frms_pkg::*;

   // Array carries no reset; only the output register is defined
   frms_word_t store [0:511];

   // Write port
   always_ff @(posedge clk) begin
      if (mif.wr_en) begin
         store[mif.wr_ptr] <= mif.wr_data;
      end
   end

   // Read port: output holds its word while no read is taken
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mif.rd_data <= 18'h00000;
      end else if (mif.rd_en) begin
         mif.rd_data <= store[mif.rd_ptr];
      end
   end
endmodule : frms_mem
`default_nettype wire

// ===== rtl/frms_axil.sv
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/10ps
`default_nettype none
`include "frms_params.svh"
module frms_axil (
   input wire logic clk,
   input wire logic arst_n,
   input wire frms_pkg::frms_addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire frms_pkg::frms_addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   frms_reg_if.bus rif
);
   import frms_pkg::*;

   logic aw_full_reg; // Address held
   logic w_full_reg;  // Data held
   frms_addr_t awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // Handshake decode; address and data may come in either order
   wire aw_take = awvalid & awready;
   wire w_take = wvalid & wready;
   wire wr_do = aw_full_reg & w_full_reg & ~bvalid;
   wire aw_full_next = (aw_full_reg | aw_take) & ~wr_do;
   wire w_full_next = (w_full_reg | w_take) & ~wr_do;
   wire bvalid_next = wr_do | (bvalid & ~bready);
   wire ar_take = arvalid & arready;
   wire rvalid_next = ar_take | (rvalid & ~rready);

   assign rif.wr_en = wr_do;
   assign rif.wr_addr = awaddr_reg;
   assign rif.wr_data = wdata_reg;
   assign rif.wr_mask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
   assign rif.rd_addr = araddr;

   // Write channels and response
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `FRMS_RESP_OKAY;
      end else begin
         aw_full_reg <= aw_full_next;
         w_full_reg <= w_full_next;
         awready <= ~aw_full_next;
         wready <= ~w_full_next;
         if (aw_take) begin
            awaddr_reg <= awaddr;
         end
         if (w_take) begin
            wdata_reg <= wdata;
            wstrb_reg <= wstrb;
         end
         bvalid <= bvalid_next;
         // Unmapped addresses answer with an error, nothing is stored
         if (wr_do) begin
            bresp <= rif.wr_hit ? `FRMS_RESP_OKAY : `FRMS_RESP_SLVERR;
         end
      end
   end

   // Read channels: data captured at the address handshake
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `FRMS_RESP_OKAY;
      end else begin
         arready <= ~rvalid_next;
         rvalid <= rvalid_next;
         if (ar_take) begin
            rdata <= rif.rd_data;
            rresp <= rif.rd_hit ? `FRMS_RESP_OKAY : `FRMS_RESP_SLVERR;
         end
      end
   end
endmodule : frms_axil
`default_nettype wire

// ===== rtl/frms_top.sv
// FIFO core with reset and mode selection, registers over AXI4-Lite
// Behaviour
// RQ1 - Writer presents words on 18-bit input bus
// RQ2 - Master reset returns both pointers to zero
// RQ3 - Reset: full, almost-full, half high; others low
// RQ4 - Reset restores offsets and control register defaults
// RQ5 - Controller resets once before first access
// RQ6 - Enhanced select during reset sets control bits high
// RQ7 - Enhanced mode: control register writable and readable
// RQ8 - Each control bit programmable in enhanced mode
// RQ9 - Interlock features enabled while enhanced select asserted
// RQ10 - Compatible mode: control hidden, held all zero
// RQ11 - Mode select kept static during operation
// RQ12 - Reset sets almost offsets to 63 words
// RQ13 - Store word on enabled write unless full
// RQ14 - Master reset spans edges of both ports
`timescale 1ns/10ps
`default_nettype none
`include "frms_params.svh"
module frms_top (
   input wire logic clk,
   input wire logic arst_n,
   input wire frms_pkg::frms_addr_t awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire frms_pkg::frms_addr_t araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire frms_pkg::frms_word_t data_in,
   input wire logic write_enable_n,
   input wire logic load_select_n,
   input wire logic read_enable_n,
   input wire logic output_enable_n,
   input wire logic master_reset_n,
   input wire logic enhanced_mode_select_n,
   output frms_pkg::frms_word_t data_out,
   output logic data_out_oe,
   output logic full_flag_n,
   output logic almost_full_flag_n,
   output logic half_full_flag_n,
   output logic almost_empty_flag_n,
   output logic empty_flag_n,
   output logic interlock_enable,
   output logic irq
);
   import frms_pkg::*;

   frms_reg_if rif();
   frms_mem_if mif();

   logic [2:0] mrst_sync_reg;  // Reset pin synchroniser
   logic [2:0] enhanced_mode_select_n_sync_reg; // Mode pin synchroniser
   logic mrst_reg;             // Master reset in force
   logic enhanced_mode_select_n_n_reg;          // Settled mode pin level
   logic enh_reg;              // Mode caught at last reset
   frms_ptr_t wr_ptr_reg;
   frms_ptr_t rd_ptr_reg;
   frms_cnt_t cnt_reg;         // Words held
   frms_ptr_t ae_ofs_reg;      // Almost-empty distance
   frms_ptr_t af_ofs_reg;      // Almost-full distance
   frms_ctrl_t ctrl_reg;       // Enhanced feature enables
   frms_irq_t irq_stat_reg;    // Sticky events
   frms_irq_t irq_mask_reg;    // Event enables

   // Pin inputs: three flops; a new level is taken once stages 2 and 3
   // agree. Both start in the reset and compatible state.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mrst_sync_reg <= 3'h0;
         enhanced_mode_select_n_sync_reg <= 3'h7;
      end else begin
         mrst_sync_reg <= {mrst_sync_reg[1:0], master_reset_n};
         enhanced_mode_select_n_sync_reg <= {enhanced_mode_select_n_sync_reg[1:0], enhanced_mode_select_n};
      end
   end

   // Settled levels; a short glitch never reaches the core
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mrst_reg <= 1'b1;
         enhanced_mode_select_n_n_reg <= 1'b1;
      end else begin
         if (mrst_sync_reg[1] == mrst_sync_reg[2]) begin
            mrst_reg <= ~mrst_sync_reg[2]; // see RQ14
         end
         if (enhanced_mode_select_n_sync_reg[1] == enhanced_mode_select_n_sync_reg[2]) begin
            enhanced_mode_select_n_n_reg <= enhanced_mode_select_n_sync_reg[2];
         end
      end
   end

   // Port qualifiers; enhanced mode with bit 05 lets a disabled output
   // suppress reading, so no word is lost while the bus is parked
   wire rd_sup = enh_reg & ctrl_reg[`FRMS_CTRL_RDSUP] & output_enable_n;
   wire wr_req = ~write_enable_n & load_select_n & ~mrst_reg;
   wire rd_req = ~read_enable_n & load_select_n & ~rd_sup & ~mrst_reg;
   wire wr_fire = wr_req & full_flag_n; // see RQ13
   wire rd_fire = rd_req & empty_flag_n;

   // Fill level; reset empties the array
   wire frms_cnt_t cnt_next = mrst_reg ? 10'h000 :
      (wr_fire & ~rd_fire) ? cnt_reg + 10'h001 :
      (rd_fire & ~wr_fire) ? cnt_reg - 10'h001 : cnt_reg;

   // Flag decode from the coming level; zero words yields the reset pattern
   wire full_n_next = cnt_next != `FRMS_DEPTH;
   wire af_n_next = cnt_next < (`FRMS_DEPTH - {1'b0, af_ofs_reg});
   wire hf_n_next = cnt_next <= `FRMS_HALF;
   wire ae_n_next = cnt_next > {1'b0, ae_ofs_reg};
   wire ef_n_next = cnt_next != 10'h000;

   // Storage connections
   assign mif.wr_en = wr_fire;
   assign mif.wr_ptr = wr_ptr_reg;
   assign mif.wr_data = data_in; // see RQ1
   assign mif.rd_en = rd_fire;
   assign mif.rd_ptr = rd_ptr_reg;

   // Pointers and level; master reset points both at location zero
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= 9'h000;
         rd_ptr_reg <= 9'h000;
         cnt_reg <= 10'h000;
      end else if (mrst_reg) begin
         wr_ptr_reg <= 9'h000; // see RQ2
         rd_ptr_reg <= 9'h000; // see RQ2
         cnt_reg <= 10'h000;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + {8'h00, wr_fire}; // see RQ13
         rd_ptr_reg <= rd_ptr_reg + {8'h00, rd_fire};
         cnt_reg <= cnt_next;
      end
   end

   // Status flags, registered so the pins never glitch
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         full_flag_n <= 1'b1;
         almost_full_flag_n <= 1'b1;
         half_full_flag_n <= 1'b1;
         almost_empty_flag_n <= 1'b0;
         empty_flag_n <= 1'b0;
      end else begin
         full_flag_n <= full_n_next; // see RQ3
         almost_full_flag_n <= af_n_next; // see RQ3
         half_full_flag_n <= hf_n_next; // see RQ3
         almost_empty_flag_n <= ae_n_next; // see RQ3
         empty_flag_n <= ef_n_next; // see RQ3
      end
   end

   // Register decode
   wire sel_ctrl = rif.wr_addr == `FRMS_A_CTRL;
   wire sel_ae = rif.wr_addr == `FRMS_A_AE_OFS;
   wire sel_af = rif.wr_addr == `FRMS_A_AF_OFS;
   wire sel_istat = rif.wr_addr == `FRMS_A_IRQ_STAT;
   wire sel_imask = rif.wr_addr == `FRMS_A_IRQ_MASK;
   assign rif.wr_hit = sel_ctrl | sel_ae | sel_af | sel_istat | sel_imask
      | (rif.wr_addr == `FRMS_A_STATUS);

   // Byte-lane merge of each writable register
   wire [31:0] ctrl_wr = ({26'h0, ctrl_reg} & ~rif.wr_mask)
      | (rif.wr_data & rif.wr_mask);
   wire [31:0] ae_wr = ({23'h0, ae_ofs_reg} & ~rif.wr_mask)
      | (rif.wr_data & rif.wr_mask);
   wire [31:0] af_wr = ({23'h0, af_ofs_reg} & ~rif.wr_mask)
      | (rif.wr_data & rif.wr_mask);
   wire [31:0] imask_wr = ({28'h0, irq_mask_reg} & ~rif.wr_mask)
      | (rif.wr_data & rif.wr_mask);

   // Control writes only land in enhanced mode; in compatible mode they
   // are answered but dropped
   wire ctrl_we = rif.wr_en & sel_ctrl & enh_reg & ~mrst_reg; // see RQ7
   wire ofs_ok = rif.wr_en & ~mrst_reg;

   // Mode caught at reset, controls and offsets
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         enh_reg <= 1'b0;
         ctrl_reg <= `FRMS_CTRL_CMP_DEF;
         ae_ofs_reg <= `FRMS_OFS_DEF;
         af_ofs_reg <= `FRMS_OFS_DEF;
      end else if (mrst_reg) begin
         // Mode pin assumed static; enh_reg samples it here only, interlock_enable follows it every cycle
         enh_reg <= ~enhanced_mode_select_n_n_reg; // see RQ11
         ctrl_reg <= enhanced_mode_select_n_n_reg ? `FRMS_CTRL_CMP_DEF
            : `FRMS_CTRL_ENH_DEF; // see RQ4, RQ6, RQ10
         ae_ofs_reg <= `FRMS_OFS_DEF; // see RQ4, RQ12
         af_ofs_reg <= `FRMS_OFS_DEF; // see RQ4, RQ12
      end else begin
         if (ctrl_we) begin
            ctrl_reg <= ctrl_wr[5:0]; // see RQ8
         end
         if (ofs_ok & sel_ae) begin
            ae_ofs_reg <= ae_wr[8:0];
         end
         if (ofs_ok & sel_af) begin
            af_ofs_reg <= af_wr[8:0];
         end
      end
   end

   // Events: refused write, refused read, became full, became empty;
   // emptying by master reset is not an event
   wire empty_fall = empty_flag_n & ~ef_n_next & ~mrst_reg;
   wire frms_irq_t irq_ev = {empty_fall, full_flag_n & ~full_n_next,
      rd_req & ~empty_flag_n, wr_req & ~full_flag_n};
   wire frms_irq_t irq_clr = (rif.wr_en & sel_istat) ? rif.wr_data[3:0]
      & rif.wr_mask[3:0] : 4'h0;
   // Set wins over a clear in the same cycle
   wire frms_irq_t irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_ev;

   // Interrupt state and outputs of the port side
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_reg <= 4'h0;
         irq_mask_reg <= 4'h0;
         irq <= 1'b0;
         interlock_enable <= 1'b0;
         data_out_oe <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (rif.wr_en & sel_imask) begin
            irq_mask_reg <= imask_wr[3:0];
         end
         irq <= |(irq_stat_reg & irq_mask_reg);
         interlock_enable <= ~enhanced_mode_select_n_n_reg; // see RQ9
         data_out_oe <= ~output_enable_n;
      end
   end

   // Read mux; control reads as zero while hidden
   // Level in [9:0] and flags above it, so a full count never merges
   wire [31:0] status_rd = {15'h0, enh_reg, interlock_enable, full_flag_n,
      almost_full_flag_n, half_full_flag_n, almost_empty_flag_n,
      empty_flag_n, cnt_reg};
   wire [31:0] ctrl_rd = enh_reg ? {26'h0, ctrl_reg} : 32'h0; // see RQ7, RQ10
   assign rif.rd_hit = (rif.rd_addr == `FRMS_A_CTRL)
      | (rif.rd_addr == `FRMS_A_AE_OFS) | (rif.rd_addr == `FRMS_A_AF_OFS)
      | (rif.rd_addr == `FRMS_A_STATUS) | (rif.rd_addr == `FRMS_A_IRQ_STAT)
      | (rif.rd_addr == `FRMS_A_IRQ_MASK);
   assign rif.rd_data =
      (rif.rd_addr == `FRMS_A_CTRL) ? ctrl_rd :
      (rif.rd_addr == `FRMS_A_AE_OFS) ? {23'h0, ae_ofs_reg} :
      (rif.rd_addr == `FRMS_A_AF_OFS) ? {23'h0, af_ofs_reg} :
      (rif.rd_addr == `FRMS_A_STATUS) ? status_rd :
      (rif.rd_addr == `FRMS_A_IRQ_STAT) ? {28'h0, irq_stat_reg} :
      (rif.rd_addr == `FRMS_A_IRQ_MASK) ? {28'h0, irq_mask_reg} : 32'h0;

   assign data_out = mif.rd_data;

   frms_mem u_mem (
      .clk(clk),
      .arst_n(arst_n),
      .mif(mif.mem)
   );

   frms_axil u_axil (
      .clk(clk),
      .arst_n(arst_n),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .rif(rif.bus)
   );

   // Checks on reset, mode and storage behaviour
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   AST_RST_SEEN: assert property (!master_reset_n [*3] |-> ##[0:2] mrst_reg) // see RQ14
      else $error("master reset not taken");
   AST_RST_PTR: assert property (mrst_reg |=> wr_ptr_reg == 9'h000 && rd_ptr_reg == 9'h000) // see RQ2
      else $error("pointers not cleared by reset");
   AST_RST_FLAGS: assert property (mrst_reg |=> full_flag_n && almost_full_flag_n
      && half_full_flag_n && !almost_empty_flag_n && !empty_flag_n) // see RQ3
      else $error("flags wrong during reset");
   AST_RST_OFS: assert property (mrst_reg |=> ae_ofs_reg == 9'h03F && af_ofs_reg == 9'h03F) // see RQ12
      else $error("offsets not defaulted");
   AST_ENH_DEF: assert property (mrst_reg && !enhanced_mode_select_n_n_reg |=> ctrl_reg == 6'h3F && enh_reg) // see RQ6
      else $error("enhanced default not applied");
   AST_CMP_ZERO: assert property (!enh_reg |-> ctrl_reg == 6'h00 && ctrl_rd == 32'h0) // see RQ10
      else $error("control visible in compatible mode");
   AST_CTRL_WR: assert property (ctrl_we |=> ctrl_reg == $past(ctrl_wr[5:0])
      ##1 rif.rd_addr != `FRMS_A_CTRL || rif.rd_data[5:0] == ctrl_reg) // see RQ8
      else $error("control write lost");
   AST_INTERLOCK: assert property (!enhanced_mode_select_n_n_reg |=> interlock_enable) // see RQ9
      else $error("interlock not enabled");
   AST_FULL_HOLD: assert property (!full_flag_n && !mrst_reg |=> $stable(wr_ptr_reg)) // see RQ13
      else $error("write stored while full");
   AST_WR_STORE: assert property (wr_fire |=> wr_ptr_reg == $past(wr_ptr_reg) + 9'h001
      && empty_flag_n) // see RQ13
      else $error("write not stored");
endmodule : frms_top
`default_nettype wire

// ===== testbench/frms_partner.sv
// System logic model that drives the FIFO data ports and pins
`timescale 1ns/10ps
`default_nettype none
module frms_partner (
   input wire logic clk,
   output frms_pkg::frms_word_t data_in,
   output logic write_enable_n,
   output logic load_select_n,
   output logic read_enable_n,
   output logic master_reset_n,
   output logic enhanced_mode_select_n,
   input wire frms_pkg::frms_word_t data_out
);
   import frms_pkg::*;

   // Power-up: reset held low before any access
   initial begin
      data_in = 18'h00000;
      write_enable_n = 1'b1;
      load_select_n = 1'b1; // High unless the ports are parked
      read_enable_n = 1'b1;
      master_reset_n = 1'b0;
      enhanced_mode_select_n = 1'b1;
   end

   // Mode pin settles before reset, stays put afterwards
   task mrst(input logic mode_n);
      @(posedge clk);
      enhanced_mode_select_n <= mode_n;
      repeat (4) @(posedge clk);
      master_reset_n <= 1'b0; // Spans many edges of the one clock
      repeat (6) @(posedge clk);
      master_reset_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask : mrst

   // Load select level; low parks both FIFO ports
   task park(input logic ld_n);
      @(posedge clk);
      load_select_n <= ld_n;
   endtask : park

   // One word on the 18-bit bus, then the bus shows junk
   task push(input frms_word_t wd);
      @(posedge clk);
      data_in <= wd;
      write_enable_n <= 1'b0;
      @(posedge clk);
      write_enable_n <= 1'b1;
      data_in <= ~wd; // Idle bus must not look like the last word
   endtask : push

   // One read; the word is taken once the edge has landed
   task pop(output frms_word_t rd);
      @(posedge clk);
      read_enable_n <= 1'b0;
      @(posedge clk);
      read_enable_n <= 1'b1;
      #1;
      rd = data_out;
   endtask : pop
endmodule : frms_partner
`default_nettype wire

// ===== testbench/testbench.sv
// Self-checking bench for the FIFO reset and mode select block
`timescale 1ns/10ps
`default_nettype none
`include "frms_params.svh"
module testbench;
   import frms_pkg::*;
   logic clk, arst_n; // Clock and bus reset
   frms_addr_t awaddr, araddr; // Bus addresses
   logic [31:0] wdata, rdata; // Bus data
   logic [3:0] wstrb; // Byte lanes
   logic awvalid, awready, wvalid, wready, bvalid, bready; // Write channels
   logic arvalid, arready, rvalid, rready; // Read channels
   logic [1:0] bresp, rresp; // Bus answers
   frms_word_t data_in, data_out, w; // FIFO words
   logic write_enable_n, load_select_n, read_enable_n, master_reset_n;
   logic enhanced_mode_select_n, data_out_oe, full_flag_n, almost_full_flag_n;
   logic half_full_flag_n, almost_empty_flag_n, empty_flag_n, interlock_enable, irq;
   logic output_enable_n; // High holds reads off while bit 05 is set
   logic [4:0] flags; // Full, almost-full, half, almost-empty, empty
   int num_errors, tests_run, cycles;

   assign flags = {full_flag_n, almost_full_flag_n, half_full_flag_n,
      almost_empty_flag_n, empty_flag_n};

   frms_top i_dut (.clk, .arst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .data_in, .write_enable_n, .load_select_n, .read_enable_n,
      .output_enable_n, .master_reset_n, .enhanced_mode_select_n, .data_out,
      .data_out_oe, .full_flag_n, .almost_full_flag_n, .half_full_flag_n,
      .almost_empty_flag_n, .empty_flag_n, .interlock_enable, .irq);

   frms_partner i_partner (.clk, .data_in, .write_enable_n, .load_select_n,
      .read_enable_n, .master_reset_n, .enhanced_mode_select_n, .data_out);

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // Hang guard: the run needs about 1300 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         results();
      end
   end

   // Compare and count
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Bus write: address and data offered together, held until taken
   task wr(input frms_addr_t a, input logic [31:0] wd, input logic [1:0] er);
      @(posedge clk);
      awaddr <= a;
      wdata <= wd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      chk("bresp", er, bresp);
      bready <= 1'b0;
   endtask : wr

   // Bus read with expected data and answer
   task rd(input frms_addr_t a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
      rready <= 1'b0;
   endtask : rd

   // Let registered outputs such as irq follow their cause
   task settle;
      repeat (2) @(negedge clk);
   endtask : settle

   // Verdict and end of run
   task results;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   // Main sequence
   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      output_enable_n = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h00000000;
      wstrb = 4'hF;
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      // Compatible mode: control hidden and zero
      i_partner.mrst(1'b1);
      chk("flags", 5'h1C, flags);
      rd(`FRMS_A_CTRL, 32'h00000000, `FRMS_RESP_OKAY);
      wr(`FRMS_A_CTRL, 32'h0000003F, `FRMS_RESP_OKAY);
      rd(`FRMS_A_CTRL, 32'h00000000, `FRMS_RESP_OKAY);
      rd(`FRMS_A_AE_OFS, 32'h0000003F, `FRMS_RESP_OKAY);
      rd(`FRMS_A_AF_OFS, 32'h0000003F, `FRMS_RESP_OKAY);
      chk("interlock", 1'b0, interlock_enable);
      // Unmapped place is refused
      wr(8'h20, 32'h00000001, `FRMS_RESP_SLVERR);
      rd(8'h20, 32'h00000000, `FRMS_RESP_SLVERR);
      // Words come back in order
      for (int i = 0; i < 3; i++) i_partner.push(18'h2A5A5 + i);
      for (int i = 0; i < 3; i++) begin
         i_partner.pop(w);
         chk("data_out", 18'h2A5A5 + i, w);
      end
      // Load select low: a write does nothing
      i_partner.park(1'b0);
      i_partner.push(18'h00001);
      i_partner.park(1'b1);
      chk("flags", 5'h1C, flags);
      // Interrupt: masked, unmasked, cleared
      wr(`FRMS_A_IRQ_MASK, 32'h00000000, `FRMS_RESP_OKAY);
      wr(`FRMS_A_IRQ_STAT, 32'h0000000F, `FRMS_RESP_OKAY);
      i_partner.pop(w);
      settle();
      chk("irq", 1'b0, irq);
      rd(`FRMS_A_IRQ_STAT, 32'h00000002, `FRMS_RESP_OKAY);
      wr(`FRMS_A_IRQ_MASK, 32'h00000002, `FRMS_RESP_OKAY);
      settle();
      chk("irq", 1'b1, irq);
      wr(`FRMS_A_IRQ_STAT, 32'h00000002, `FRMS_RESP_OKAY);
      settle();
      chk("irq", 1'b0, irq);
      // Fill to the top, then one write too many
      for (int i = 0; i < 512; i++) i_partner.push(18'h00100 + i);
      settle();
      chk("flags", 5'h03, flags);
      i_partner.push(18'h3FFFF);
      rd(`FRMS_A_STATUS, 32'h00000E00, `FRMS_RESP_OKAY);
      rd(`FRMS_A_IRQ_STAT, 32'h00000005, `FRMS_RESP_OKAY);
      // Reset while full: pointers and flags back to the start
      i_partner.mrst(1'b1);
      chk("flags", 5'h1C, flags);
      rd(`FRMS_A_STATUS, 32'h00007000, `FRMS_RESP_OKAY);
      i_partner.push(18'h15555);
      i_partner.pop(w);
      chk("data_out", 18'h15555, w);
      // Enhanced mode: control set, visible and programmable
      i_partner.mrst(1'b0);
      rd(`FRMS_A_CTRL, 32'h0000003F, `FRMS_RESP_OKAY);
      chk("interlock", 1'b1, interlock_enable);
      for (int i = 0; i < 6; i++) begin
         wr(`FRMS_A_CTRL, 32'h00000001 << i, `FRMS_RESP_OKAY);
         rd(`FRMS_A_CTRL, 32'h00000001 << i, `FRMS_RESP_OKAY);
      end
      // Output disabled with bit 05 set holds reading off
      output_enable_n <= 1'b1;
      i_partner.push(18'h0A5A5);
      i_partner.pop(w);
      chk("data_out_oe", 1'b0, data_out_oe);
      chk("flags", 5'h1D, flags);
      @(posedge clk) output_enable_n <= 1'b0;
      i_partner.pop(w);
      chk("data_out", 18'h0A5A5, w);
      wr(`FRMS_A_AE_OFS, 32'h00000005, `FRMS_RESP_OKAY);
      rd(`FRMS_A_AE_OFS, 32'h00000005, `FRMS_RESP_OKAY);
      // Byte lane 1 only: low byte kept
      wstrb <= 4'h2;
      wr(`FRMS_A_AE_OFS, 32'h000001FF, `FRMS_RESP_OKAY);
      wstrb <= 4'hF;
      rd(`FRMS_A_AE_OFS, 32'h00000105, `FRMS_RESP_OKAY);
      i_partner.mrst(1'b0);
      rd(`FRMS_A_AE_OFS, 32'h0000003F, `FRMS_RESP_OKAY);
      rd(`FRMS_A_CTRL, 32'h0000003F, `FRMS_RESP_OKAY);
      // Back to compatible mode
      i_partner.mrst(1'b1);
      rd(`FRMS_A_CTRL, 32'h00000000, `FRMS_RESP_OKAY);
      chk("interlock", 1'b0, interlock_enable);
      results();
   end
endmodule : testbench
`default_nettype wire
